//--- src/spims_top.sv
// serial master with select modes and mode-fault detection
// What this block does
// - every finished byte sets the transfer-done flag.
// - a set transfer-done flag raises the interrupt when enabled.
// - the byte goes out on mosi while the slave byte comes in on miso.
// - the incoming byte is shifted in most significant bit first.
// - a complete received byte is copied to the receive buffer for reading.
// - after reset the mode is multi-master, select line as input.
// - select low in multi-master while both enables are set clears both and sets the fault flag.
// - a set fault flag raises the interrupt when enabled.
// - both select bits low gives 3-wire mode with the select line unused.
// - high select bit set gives 4-wire mode with the select line driven.
// - in 4-wire mode the select line follows the low select bit.
`timescale 1ns/1ps
module spims_top
    import spims_pkg::*;
(
    input  wire logic                              sys_clk,
    input  wire logic                              rst_n,
    input  wire logic                              link_clk,
    input  wire logic                              ctrl_wr,
    input  wire logic                              wr_port_enable,
    input  wire logic                              wr_master_enable,
    input  wire logic                              wr_select_mode_high,
    input  wire logic                              wr_select_mode_low,
    input  wire logic                              wr_int_enable,
    input  wire logic                              data_wr,
    input  wire logic [spims_pkg::SPIMS_BITS-1:0]  data_wdata,
    input  wire logic                              clr_done,
    input  wire logic                              clr_fault,
    output logic                                   port_enable_bit,
    output logic                                   master_enable_bit,
    output logic                                   select_mode_high_bit,
    output logic                                   select_mode_low_bit,
    output logic                                   int_enable_bit,
    output logic                                   transfer_done_flag,
    output logic                                   mode_fault_flag,
    output logic                                   busy,
    output logic [spims_pkg::SPIMS_BITS-1:0]       shift_data_register,
    output logic                                   irq,
    output logic                                   sck_o,
    output logic                                   sck_oe,
    output logic                                   mosi_o,
    output logic                                   mosi_oe,
    input  wire logic                              miso_i,
    input  wire logic                              slave_select_line_i,
    output logic                                   slave_select_line_o,
    output logic                                   slave_select_line_oe
);
    import spims_pkg::*;

    logic                      port_en_q;
    logic                      master_en_q;
    logic                      sel_hi_q;
    logic                      sel_lo_q;
    logic                      int_en_q;
    logic                      done_q;
    logic                      fault_q;
    logic                      busy_q;
    logic                      irq_q;
    logic                      start_tgl_q;
    logic                      done_seen_q;
    logic [SPIMS_BITS-1:0]     tx_q;
    logic [SPIMS_BITS-1:0]     rx_q;
    logic [SPIMS_BITS-1:0]     eng_rx;
    logic                      eng_done_tgl;
    logic                      done_tgl_s;
    logic                      done_pulse;
    logic                      nss_s;
    logic                      fault_cond;
    logic                      start_ok;
    logic                      drive_pins;
    logic                      link_rst_n;
    logic                      start_tgl_s;
    logic                      miso_s;
    spims_mode_type            mode;

    // system clock side

    spims_sync u_nss_sync (
        .clk (sys_clk),
        .d   (slave_select_line_i),
        .q   (nss_s)
    );

    spims_sync u_done_sync (
        .clk (sys_clk),
        .d   (eng_done_tgl),
        .q   (done_tgl_s)
    );

    assign mode       = spims_mode(sel_hi_q, sel_lo_q);
    assign done_pulse = (done_tgl_s ^ done_seen_q) & busy_q;

    assign fault_cond = (mode == SPIMS_MULTI) && port_en_q && master_en_q && !nss_s;

    assign start_ok   = data_wr && !busy_q && port_en_q && master_en_q && !fault_cond;
    assign drive_pins = port_en_q && master_en_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            done_seen_q <= 1'b0;
        end else begin
            done_seen_q <= done_tgl_s;
        end
    end

    // no self re-enable, only a write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            port_en_q   <= SPIMS_EN_RST;
            master_en_q <= SPIMS_EN_RST;
        end else if (fault_cond) begin
            port_en_q   <= 1'b0;
            master_en_q <= 1'b0;
        end else if (ctrl_wr) begin
            port_en_q   <= wr_port_enable;
            master_en_q <= wr_master_enable;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_hi_q <= SPIMS_SEL_HI_RST;
            sel_lo_q <= SPIMS_SEL_LO_RST;
            int_en_q <= SPIMS_EN_RST;
        end else if (ctrl_wr) begin
            sel_hi_q <= wr_select_mode_high;
            sel_lo_q <= wr_select_mode_low;
            int_en_q <= wr_int_enable;
        end
    end

    // finish sets done, set beats clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            done_q <= SPIMS_FLAG_RST;
        end else if (done_pulse) begin
            done_q <= 1'b1;
        end else if (clr_done) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fault_q <= SPIMS_FLAG_RST;
        end else if (fault_cond) begin
            fault_q <= 1'b1;
        end else if (clr_fault) begin
            fault_q <= 1'b0;
        end
    end

    // tx word stays still while busy, so the link side may read it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            busy_q      <= 1'b0;
            tx_q        <= SPIMS_DATA_RST;
            start_tgl_q <= 1'b0;
        end else if (start_ok) begin
            busy_q      <= 1'b1;
            tx_q        <= data_wdata;
            start_tgl_q <= ~start_tgl_q;
        end else if (done_pulse) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_q <= SPIMS_DATA_RST;
        end else if (done_pulse) begin
            rx_q <= eng_rx;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= int_en_q && (done_q || fault_q);
        end
    end

    always_comb begin
        slave_select_line_oe = 1'b0;
        slave_select_line_o  = 1'b1;
        if (mode == SPIMS_FOUR) begin
            slave_select_line_oe = 1'b1;
            slave_select_line_o  = sel_lo_q;
        end
    end

    // a started byte still finishes inside after a fault; pins are released at once
    assign sck_oe               = drive_pins;
    assign mosi_oe              = drive_pins;
    assign port_enable_bit      = port_en_q;
    assign master_enable_bit    = master_en_q;
    assign select_mode_high_bit = sel_hi_q;
    assign select_mode_low_bit  = sel_lo_q;
    assign int_enable_bit       = int_en_q;
    assign transfer_done_flag   = done_q;
    assign mode_fault_flag      = fault_q;
    assign busy                 = busy_q;
    assign shift_data_register  = rx_q;
    assign irq                  = irq_q;

    // link clock side

    spims_sync u_rst_sync (
        .clk (link_clk),
        .d   (rst_n),
        .q   (link_rst_n)
    );

    spims_sync u_start_sync (
        .clk (link_clk),
        .d   (start_tgl_q),
        .q   (start_tgl_s)
    );

    spims_sync u_miso_sync (
        .clk (link_clk),
        .d   (miso_i),
        .q   (miso_s)
    );

    spims_shifter u_shifter (
        .link_clk   (link_clk),
        .link_rst_n (link_rst_n),
        .start_tgl  (start_tgl_s),
        .tx_data    (tx_q),
        .miso_s     (miso_s),
        .sck_o      (sck_o),
        .mosi_o     (mosi_o),
        .rx_data    (eng_rx),
        .done_tgl   (eng_done_tgl)
    );

    // checks

    a_done_sets_flag:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        done_pulse |=> done_q && !busy_q)
        else $error("finished byte did not set done");

    a_irq_on_done:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        (done_q && int_en_q) |=> irq_q)
        else $error("done flag did not raise interrupt");

    a_rx_buffer_copy:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        done_pulse |=> rx_q == $past(eng_rx))
        else $error("received byte not copied to buffer");

    a_reset_multi_mode:
    assert property (@(posedge sys_clk)
        $past(!rst_n) |-> (!sel_hi_q && sel_lo_q && !slave_select_line_oe))
        else $error("reset mode is not multi-master");

    a_fault_clears_en:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        fault_cond |=> !port_en_q && !master_en_q && fault_q)
        else $error("fault did not clear enables and set flag");

    a_irq_on_fault:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fault_q && int_en_q) |=> irq_q)
        else $error("fault flag did not raise interrupt");

    a_three_wire_idle:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!sel_hi_q && !sel_lo_q) |-> !slave_select_line_oe)
        else $error("select pin driven in 3-wire mode");

    a_four_wire_out:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        sel_hi_q |-> slave_select_line_oe && slave_select_line_o == sel_lo_q)
        else $error("select pin does not follow low select bit");

    a_single_no_fault:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((sel_hi_q || !sel_lo_q) && !fault_q) |=> !fault_q || $past(ctrl_wr))
        else $error("fault raised outside multi-master mode");

    a_multi_sel_input:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!sel_hi_q && sel_lo_q) |-> !slave_select_line_oe)
        else $error("select pin driven in multi-master mode");

    a_fault_pins_off:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
        fault_cond |=> !sck_oe && !mosi_oe)
        else $error("fault did not release the link pins");
endmodule : spims_top

//--- src/spims_pkg.sv
// constants, types and helpers shared by the serial master files
package spims_pkg;
    localparam int unsigned    SPIMS_BITS      = 8;
    localparam logic [1:0]     SPIMS_PH_FIRST  = 2'h0;
    localparam logic [1:0]     SPIMS_PH_LAST   = 2'h3;
    localparam logic [1:0]     SPIMS_PH_RISE   = 2'h1;
    localparam logic [1:0]     SPIMS_PH_HIGH   = 2'h2;
    localparam logic [2:0]     SPIMS_BIT_LAST  = 3'h7;
    localparam logic [2:0]     SPIMS_BIT_FIRST = 3'h0;
    localparam logic [7:0]     SPIMS_DATA_RST  = 8'h00;
    localparam logic           SPIMS_SEL_HI_RST = 1'b0;
    localparam logic           SPIMS_SEL_LO_RST = 1'b1;
    localparam logic           SPIMS_EN_RST    = 1'b0;
    localparam logic           SPIMS_FLAG_RST  = 1'b0;

    typedef enum logic [1:0] {
        SPIMS_MULTI,
        SPIMS_THREE,
        SPIMS_FOUR
    } spims_mode_type;

    typedef enum logic {
        SPIMS_IDLE,
        SPIMS_SHIFT
    } spims_eng_type;

    // select-mode bits to operating mode
    function automatic spims_mode_type spims_mode(input logic hi, input logic lo);
        spims_mode_type m;
        m = SPIMS_FOUR;
        if (!hi) begin
            m = lo ? SPIMS_MULTI : SPIMS_THREE;
        end
        return m;
    endfunction : spims_mode
endpackage : spims_pkg

//--- src/spims_sync.sv
// two-flop synchroniser for one level
`timescale 1ns/1ps
module spims_sync (
    input  wire logic clk,
    input  wire logic d,
    output logic      q
);
    logic meta_q;

    // no reset: output follows the input within two edges anyway
    always_ff @(posedge clk) begin
        meta_q <= d;
        q      <= meta_q;
    end
endmodule : spims_sync

//--- src/spims_shifter.sv
// link-clock shift engine: one byte out and in, msb first
`timescale 1ns/1ps
module spims_shifter
    import spims_pkg::*;
(
    input  wire logic                              link_clk,
    input  wire logic                              link_rst_n,
    input  wire logic                              start_tgl,
    input  wire logic [spims_pkg::SPIMS_BITS-1:0]  tx_data,
    input  wire logic                              miso_s,
    output logic                                   sck_o,
    output logic                                   mosi_o,
    output logic [spims_pkg::SPIMS_BITS-1:0]       rx_data,
    output logic                                   done_tgl
);
    spims_eng_type               state_q;
    logic [1:0]                  ph_q;
    logic [2:0]                  bit_q;
    logic [SPIMS_BITS-1:0]       shreg_q;
    logic                        start_seen_q;
    logic                        start_pulse;

    assign start_pulse = start_tgl ^ start_seen_q;
    assign mosi_o      = shreg_q[SPIMS_BITS-1];

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            start_seen_q <= 1'b0;
        end else begin
            start_seen_q <= start_tgl;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            state_q  <= SPIMS_IDLE;
            ph_q     <= SPIMS_PH_FIRST;
            bit_q    <= SPIMS_BIT_LAST;
            shreg_q  <= SPIMS_DATA_RST;
            rx_data  <= SPIMS_DATA_RST;
            done_tgl <= 1'b0;
        end else begin
            case (state_q)
                SPIMS_IDLE: begin
                    if (start_pulse) begin
                        shreg_q <= tx_data;
                        ph_q    <= SPIMS_PH_FIRST;
                        bit_q   <= SPIMS_BIT_LAST;
                        state_q <= SPIMS_SHIFT;
                    end
                end
                SPIMS_SHIFT: begin
                    ph_q <= 2'(ph_q + 2'h1);
                    if (ph_q == SPIMS_PH_LAST) begin
                        shreg_q <= {shreg_q[SPIMS_BITS-2:0], miso_s};
                        if (bit_q == SPIMS_BIT_FIRST) begin
                            rx_data  <= {shreg_q[SPIMS_BITS-2:0], miso_s};
                            done_tgl <= ~done_tgl;
                            state_q  <= SPIMS_IDLE;
                        end else begin
                            bit_q <= bit_q - 3'h1;
                        end
                    end
                end
                default: state_q <= SPIMS_IDLE;
            endcase
        end
    end

    // clock high for the second half of each bit
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            sck_o <= 1'b0;
        end else begin
            sck_o <= (state_q == SPIMS_SHIFT) &&
                     (ph_q == SPIMS_PH_RISE || ph_q == SPIMS_PH_HIGH);
        end
    end

    a_msb_first_in:
    assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (state_q == SPIMS_SHIFT && ph_q == SPIMS_PH_LAST) |=> shreg_q[0] == $past(miso_s))
        else $error("received bit not shifted in at lsb end");
endmodule : spims_shifter

//--- tb/spims_slave_model.sv
// behavioural serial slave: answers a byte while taking one, msb first
`timescale 1ns/1ps
module spims_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       rearm,
    input  wire logic       lag,
    input  wire logic [7:0] reply,
    output logic            miso,
    output logic [7:0]      got
);
    logic [7:0] sh;
    int         cnt;

    initial begin
        miso = 1'b0;
        got = 8'h00;
        sh = 8'h00;
        cnt = 8;
    end

    always @(rearm) begin
        sh = reply;
        cnt = 0;
        miso = reply[7];
    end

    always @(posedge sck) begin
        got = {got[6:0], mosi};
    end

    // slow mode lands late but inside the bit; after the frame the line toggles on each falling clock
    always @(negedge sck) begin
        cnt++;
        sh = {sh[6:0], 1'b0};
        if (cnt < 8) begin
            miso <= #(lag ? 100 : 5) sh[7];
        end else begin
            miso <= #(lag ? 100 : 5) ~miso;
        end
    end
endmodule : spims_slave_model

//--- tb/tb.sv
// bench for the serial master: select modes, mode fault and byte exchange
`timescale 1ns/1ps
module tb;
    import spims_pkg::*;
    logic       sys_clk, rst_n, link_clk, ctrl_wr, data_wr, clr_done, clr_fault;
    logic       w_pe, w_me, w_hi, w_lo, w_ie, pe, me, hi, lo, ie, done, fault, busy, irq;
    logic [7:0] data_wdata, rx_buf, slv_got, reply;
    logic       sck, sck_oe, mosi, mosi_oe, miso, ss_o, ss_oe, ss_drv, ss_pin, rearm, lag;
    int         err_total, checks_done, cyc;

    assign ss_pin = ss_oe ? ss_o : ss_drv;

    spims_top spims_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
        .ctrl_wr(ctrl_wr), .wr_port_enable(w_pe), .wr_master_enable(w_me),
        .wr_select_mode_high(w_hi), .wr_select_mode_low(w_lo), .wr_int_enable(w_ie),
        .data_wr(data_wr), .data_wdata(data_wdata), .clr_done(clr_done),
        .clr_fault(clr_fault), .port_enable_bit(pe), .master_enable_bit(me),
        .select_mode_high_bit(hi), .select_mode_low_bit(lo), .int_enable_bit(ie),
        .transfer_done_flag(done), .mode_fault_flag(fault), .busy(busy),
        .shift_data_register(rx_buf), .irq(irq), .sck_o(sck), .sck_oe(sck_oe),
        .mosi_o(mosi), .mosi_oe(mosi_oe), .miso_i(miso), .slave_select_line_i(ss_pin),
        .slave_select_line_o(ss_o), .slave_select_line_oe(ss_oe));

    spims_slave_model spims_slave_model_i (.sck(sck), .mosi(mosi), .rearm(rearm),
        .lag(lag), .reply(reply), .miso(miso), .got(slv_got));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        link_clk = 1'b0;
        #7;
        forever #62.5 link_clk = ~link_clk;
    end

    task automatic complete_run();
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic ctrl(input logic pe_v, me_v, hi_v, lo_v, ie_v);
        @(posedge sys_clk);
        ctrl_wr <= 1'b1;
        w_pe <= pe_v;
        w_me <= me_v;
        w_hi <= hi_v;
        w_lo <= lo_v;
        w_ie <= ie_v;
        @(posedge sys_clk);
        ctrl_wr <= 1'b0;
        tick(1);
    endtask : ctrl

    // one byte each way; waits for the done flag under a bound
    task automatic xfer(input logic [7:0] tx, input logic [7:0] rp, input logic lg);
        int n;
        reply = rp;
        lag = lg;
        rearm = ~rearm;
        @(posedge sys_clk);
        data_wr <= 1'b1;
        data_wdata <= tx;
        @(posedge sys_clk);
        data_wr <= 1'b0;
        #1;
        cmp("busy", 8'h01, {7'h00, busy});
        n = 0;
        while (done !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        cmp("done", 8'h01, {7'h00, done});
        cmp("rx buffer", rp, rx_buf);
        cmp("slave byte", tx, slv_got);
        tick(1);
        cmp("irq", {7'h00, w_ie}, {7'h00, irq});
        @(posedge sys_clk);
        clr_done <= 1'b1;
        @(posedge sys_clk);
        clr_done <= 1'b0;
        tick(1);
        cmp("done", 8'h00, {7'h00, done});
        cmp("irq", 8'h00, {7'h00, irq});
    endtask : xfer

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        {err_total, checks_done, cyc} = '0;
        {rst_n, ctrl_wr, data_wr, clr_done, clr_fault, rearm, lag} = '0;
        {w_pe, w_me, w_hi, w_lo, w_ie} = '0;
        data_wdata = 8'h00;
        reply = 8'h00;
        ss_drv = 1'b1;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(1);
        cmp("select bits", 8'h01, {6'h00, hi, lo});
        cmp("enables", 8'h00, {6'h00, pe, me});
        cmp("flags", 8'h00, {6'h00, done, fault});
        cmp("rx buffer", 8'h00, rx_buf);
        cmp("select pin", 8'h01, {6'h00, ss_oe, ss_o});
        cmp("int and pins", 8'h00, {5'h00, ie, sck_oe, mosi_oe});
        repeat (4) @(posedge link_clk);
        ctrl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        cmp("select pin", 8'h02, {6'h00, ss_oe, ss_o});
        cmp("int enable", 8'h01, {7'h00, ie});
        ctrl(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        cmp("select pin", 8'h03, {6'h00, ss_oe, ss_o});
        xfer(8'hA5, 8'h3C, 1'b0);
        ctrl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        cmp("select oe", 8'h00, {7'h00, ss_oe});
        @(posedge sys_clk);
        ss_drv <= 1'b0;
        tick(6);
        cmp("enables", 8'h03, {6'h00, pe, me});
        cmp("fault", 8'h00, {7'h00, fault});
        xfer(8'h81, 8'h7E, 1'b1);
        ss_drv <= 1'b1;
        ctrl(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        xfer(8'h00, 8'hFF, 1'b0);
        ctrl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        ss_drv <= 1'b0;
        tick(6);
        cmp("enables", 8'h00, {6'h00, pe, me});
        cmp("fault", 8'h01, {7'h00, fault});
        cmp("pin enables", 8'h00, {6'h00, sck_oe, mosi_oe});
        cmp("irq", 8'h01, {7'h00, irq});
        ss_drv <= 1'b1;
        @(posedge sys_clk);
        data_wr <= 1'b1;
        @(posedge sys_clk);
        data_wr <= 1'b0;
        tick(8);
        cmp("enables", 8'h00, {6'h00, pe, me});
        cmp("busy", 8'h00, {7'h00, busy});
        @(posedge sys_clk);
        clr_fault <= 1'b1;
        @(posedge sys_clk);
        clr_fault <= 1'b0;
        tick(2);
        cmp("fault", 8'h00, {7'h00, fault});
        ctrl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        cmp("enables", 8'h03, {6'h00, pe, me});
        cmp("pin enables", 8'h03, {6'h00, sck_oe, mosi_oe});
        xfer(8'h5A, 8'hC3, 1'b0);
        complete_run();
    end
endmodule : tb
